/* File: logic/swr_pkg.sv */
// Package for the single-wire ROM function layer: register map, timing
// counts, state encoding and the bus and state carriers.
// Assumes a 100 MHz system clock; all counts are derived from it here.
package swr_pkg;

    // Clock and times, each time in microseconds
    localparam int CLK_MHZ        = 100;
    localparam int RST_STD_US     = 120;
    localparam int RST_FAST_US    = 12;
    localparam int RST_LONG_US    = 690;
    localparam int PRES_WAIT_STD_US  = 30;
    localparam int PRES_WAIT_FAST_US = 3;
    localparam int PRES_LOW_STD_US   = 120;
    localparam int PRES_LOW_FAST_US  = 12;
    localparam int SLOT_STD_US    = 30;
    localparam int SLOT_FAST_US   = 3;

    localparam int CNT_W = 17;
    typedef logic [CNT_W-1:0] swr_cnt_type;

    // Cycle counts
    localparam swr_cnt_type SWR_RST_STD_CYC   = swr_cnt_type'(RST_STD_US * CLK_MHZ);
    localparam swr_cnt_type SWR_RST_FAST_CYC  = swr_cnt_type'(RST_FAST_US * CLK_MHZ);
    localparam swr_cnt_type SWR_RST_LONG_CYC  = swr_cnt_type'(RST_LONG_US * CLK_MHZ);
    localparam swr_cnt_type SWR_PDH_STD_CYC   = swr_cnt_type'(PRES_WAIT_STD_US * CLK_MHZ);
    localparam swr_cnt_type SWR_PDH_FAST_CYC  = swr_cnt_type'(PRES_WAIT_FAST_US * CLK_MHZ);
    localparam swr_cnt_type SWR_PDL_STD_CYC   = swr_cnt_type'(PRES_LOW_STD_US * CLK_MHZ);
    localparam swr_cnt_type SWR_PDL_FAST_CYC  = swr_cnt_type'(PRES_LOW_FAST_US * CLK_MHZ);
    localparam swr_cnt_type SWR_SLOT_STD_CYC  = swr_cnt_type'(SLOT_STD_US * CLK_MHZ);
    localparam swr_cnt_type SWR_SLOT_FAST_CYC = swr_cnt_type'(SLOT_FAST_US * CLK_MHZ);

    // ROM command codes
    localparam logic [7:0] CMD_READ_ID    = 8'h33;
    localparam logic [7:0] CMD_MATCH      = 8'h55;
    localparam logic [7:0] CMD_SEARCH     = 8'hf0;
    localparam logic [7:0] CMD_ALM_SEARCH = 8'hec;
    localparam logic [7:0] CMD_SKIP       = 8'hcc;
    localparam logic [7:0] CMD_RESUME     = 8'ha5;
    localparam logic [7:0] CMD_FAST_SKIP  = 8'h3c;
    localparam logic [7:0] CMD_FAST_MATCH = 8'h69;

    // Register map, byte addresses
    localparam int ADDR_W = 12;
    localparam logic [ADDR_W-1:0] REG_ID_LO        = 12'h000;
    localparam logic [ADDR_W-1:0] REG_ID_HI        = 12'h004;
    localparam logic [ADDR_W-1:0] REG_ALARM_ENABLE = 12'h008;
    localparam logic [ADDR_W-1:0] REG_LINK_STATUS  = 12'h00c;
    localparam logic [ADDR_W-1:0] REG_ALARM_FLAGS  = 12'h214;

    // Field positions
    localparam int STAT_RESUME_BIT = 0;
    localparam int STAT_FAST_BIT   = 1;
    localparam int STAT_FUNC_BIT   = 2;
    localparam int STAT_STATE_LSB  = 8;
    localparam int ALARM_BROWNOUT_BIT = 4;

    // Reset values; the identity value is arbitrary
    localparam logic [63:0] ID_RESET           = 64'h5a00_0000_0000_0011;
    localparam logic [3:0]  ALARM_ENABLE_RESET = 4'h0;

    typedef enum logic [3:0] {
        ST_HALT      = 4'h0,
        ST_RST       = 4'h1,
        ST_PRES_WAIT = 4'h2,
        ST_PRES_LOW  = 4'h3,
        ST_CMD       = 4'h4,
        ST_READ_ID   = 4'h5,
        ST_MATCH     = 4'h6,
        ST_SEARCH    = 4'h7,
        ST_FUNC      = 4'h8
    } swr_state_type;

    typedef struct packed {
        logic              read;
        logic              write;
        logic [ADDR_W-1:0] address;
        logic [31:0]       writedata;
    } swr_avs_req_type;

    typedef struct packed {
        swr_state_type state;
        logic          pull_n;
        logic          line_d;
        swr_cnt_type   low_cnt;
        swr_cnt_type   cnt;
        logic          slot_on;
        logic [5:0]    idx;
        logic [1:0]    phase;
        logic          mism;
        logic [7:0]    cmd;
        logic          fast_speed_flag;
        logic          fast_prev;
        logic          resume_flag;
        logic          fn_active;
        logic          bus_reset;
        logic          waitrequest;
        logic [31:0]   readdata;
        logic [63:0]   rom_id;
        logic [3:0]    alarm_enable;
    } swr_state_reg_type;

endpackage

/* File: logic/swr_sync.sv */
// Two-stage synchroniser for the single-wire line input.
// Assumes an asynchronous level; resets to the idle-high line level.
`timescale 1ns/1ns
`default_nettype none
module swr_sync (
    // Clock and reset
    input  wire logic clk,
    input  wire logic sys_rst,
    // Level in and out
    input  wire logic d,
    output logic      q
);
    typedef struct packed {
        logic meta;
        logic stable;
    } swr_sync_type;

    swr_sync_type r;
    swr_sync_type next_r;

    always_comb begin
        next_r.meta   = d;
        next_r.stable = r.meta;
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            r <= '{meta: 1'b1, stable: 1'b1};
        end else begin
            r <= next_r;
        end
    end

    assign q = r.stable;
endmodule
`default_nettype wire

/* File: logic/swr_rom_layer.sv */
// ROM function layer of a single-wire open-drain slave: reset/presence,
// eight ROM commands, speed switching and an Avalon-MM register slave.
// Assumes the line pin is pulled up outside; slot and function layers
// beyond the ROM phase belong to other logic watching fn_active.
//
// Implementation choice: the Avalon-MM slave port.
`timescale 1ns/1ns
`default_nettype none
module swr_rom_layer
    import swr_pkg::*;
#(
    parameter swr_cnt_type RST_STD_CYC  = SWR_RST_STD_CYC,
    parameter swr_cnt_type RST_LONG_CYC = SWR_RST_LONG_CYC,
    parameter swr_cnt_type PDL_STD_CYC  = SWR_PDL_STD_CYC
) (
    // Clock and reset
    input  wire logic            clk,
    input  wire logic            sys_rst,
    // Single-wire line pin
    input  wire logic            line_in,
    output logic                 line_out,
    output logic                 line_oe_n,
    // Avalon-MM slave
    input  wire swr_avs_req_type avs_req,
    output logic                 avs_waitrequest,
    output logic [31:0]          avs_readdata,
    // Alarm flags from the mission logic, brownout in bit 4
    input  wire logic [4:0]      alarm_flags,
    // Status towards the function layer
    output logic                 fn_active,
    output logic                 fast_speed_flag,
    output logic                 resume_flag,
    output logic                 bus_reset
);
    swr_state_reg_type r;
    swr_state_reg_type next_r;
    logic              line_s;

    swr_sync u_line_sync (
        .clk     (clk),
        .sys_rst (sys_rst),
        .d       (line_in),
        .q       (line_s)
    );

    function automatic swr_cnt_type by_speed(input logic fast, input swr_cnt_type std_cyc,
                                             input swr_cnt_type fast_cyc);
        return fast ? fast_cyc : std_cyc;
    endfunction

    // Brownout always counts; the other four only when enabled
    function automatic logic alarm_qualifies(input logic [4:0] flags, input logic [3:0] en);
        return flags[ALARM_BROWNOUT_BIT] | (|(flags[3:0] & en));
    endfunction

    function automatic logic [31:0] reg_read(input swr_state_reg_type s,
                                             input logic [ADDR_W-1:0] addr,
                                             input logic [4:0] flags);
        logic [31:0] v;
        v = 32'h0000_0000;
        unique case (addr)
            REG_ID_LO:        v = s.rom_id[31:0];
            REG_ID_HI:        v = s.rom_id[63:32];
            REG_ALARM_ENABLE: v = {28'h000_0000, s.alarm_enable};
            REG_LINK_STATUS: begin
                v[STAT_RESUME_BIT]                  = s.resume_flag;
                v[STAT_FAST_BIT]                    = s.fast_speed_flag;
                v[STAT_FUNC_BIT]                    = s.fn_active;
                v[STAT_STATE_LSB +: 4]              = s.state;
            end
            REG_ALARM_FLAGS:  v = {27'h000_0000, flags};
            default:          v = 32'h0000_0000;
        endcase
        return v;
    endfunction

    logic        is_read_slot;
    logic        tx_bit;
    logic        rx_bit;
    logic        slot_end;
    logic [7:0]  code;
    swr_cnt_type rst_thr;

    always_comb begin
        next_r           = r;
        next_r.bus_reset = 1'b0;
        next_r.line_d    = line_s;
        rx_bit           = line_s;
        code             = {line_s, r.cmd[7:1]};
        // Search phases 0 and 1 and identity reads are slave-to-master slots
        is_read_slot = (r.state == ST_READ_ID) ||
                       ((r.state == ST_SEARCH) && (r.phase != 2'd2));
        tx_bit       = (r.state == ST_SEARCH && r.phase == 2'd1) ? ~r.rom_id[r.idx]
                                                                  : r.rom_id[r.idx];
        slot_end     = r.slot_on &&
                       (r.cnt == by_speed(r.fast_speed_flag, SWR_SLOT_STD_CYC,
                                          SWR_SLOT_FAST_CYC));
        rst_thr      = by_speed(r.fast_speed_flag, RST_STD_CYC, SWR_RST_FAST_CYC);

        // Our own pulldown must not count as a master low
        if (line_s) begin
            next_r.low_cnt = '0;
        end else if (r.pull_n && r.low_cnt != '1) begin
            next_r.low_cnt = r.low_cnt + 1'b1;
        end

        if (!line_s && r.pull_n && r.low_cnt == rst_thr && r.state != ST_RST) begin
            // Reset pulse aborts whatever was in progress
            next_r.state     = ST_RST;
            next_r.slot_on   = 1'b0;
            next_r.bus_reset = 1'b1;
        end else begin
            unique case (r.state)
                ST_HALT, ST_FUNC: begin
                end
                ST_RST: begin
                    if (line_s) begin
                        if (r.low_cnt >= RST_LONG_CYC) begin
                            next_r.fast_speed_flag = 1'b0;
                        end
                        next_r.state = ST_PRES_WAIT;
                        next_r.cnt   = '0;
                    end
                end
                ST_PRES_WAIT: begin
                    next_r.cnt = r.cnt + 1'b1;
                    if (r.cnt == by_speed(r.fast_speed_flag, SWR_PDH_STD_CYC,
                                          SWR_PDH_FAST_CYC)) begin
                        next_r.pull_n = 1'b0;
                        next_r.cnt    = '0;
                        next_r.state  = ST_PRES_LOW;
                    end
                end
                ST_PRES_LOW: begin
                    next_r.cnt = r.cnt + 1'b1;
                    if (r.cnt == by_speed(r.fast_speed_flag, PDL_STD_CYC,
                                          SWR_PDL_FAST_CYC)) begin
                        next_r.pull_n  = 1'b1;
                        next_r.state   = ST_CMD;
                        next_r.idx     = '0;
                        next_r.slot_on = 1'b0;
                    end
                end
                ST_CMD, ST_READ_ID, ST_MATCH, ST_SEARCH: begin
                    if (!r.slot_on && r.line_d && !line_s) begin
                        // Falling edge from the master opens a slot
                        next_r.slot_on = 1'b1;
                        next_r.cnt     = '0;
                        if (is_read_slot && !tx_bit) begin
                            next_r.pull_n = 1'b0;
                        end
                    end else if (slot_end) begin
                        next_r.slot_on = 1'b0;
                        next_r.pull_n  = 1'b1;
                        unique case (r.state)
                            ST_CMD: begin
                                next_r.cmd = code;
                                next_r.idx = r.idx + 1'b1;
                                if (r.idx == 6'd7) begin
                                    next_r.idx   = '0;
                                    next_r.phase = 2'd0;
                                    next_r.mism  = 1'b0;
                                    unique case (code)
                                        CMD_READ_ID: begin
                                            next_r.resume_flag = 1'b0;
                                            next_r.state       = ST_READ_ID;
                                        end
                                        CMD_MATCH: begin
                                            next_r.state = ST_MATCH;
                                        end
                                        CMD_FAST_MATCH: begin
                                            next_r.fast_prev       = r.fast_speed_flag;
                                            next_r.fast_speed_flag = 1'b1;
                                            next_r.state           = ST_MATCH;
                                        end
                                        CMD_SEARCH: begin
                                            next_r.state = ST_SEARCH;
                                        end
                                        CMD_ALM_SEARCH: begin
                                            if (alarm_qualifies(alarm_flags,
                                                                r.alarm_enable)) begin
                                                next_r.state = ST_SEARCH;
                                            end else begin
                                                next_r.resume_flag = 1'b0;
                                                next_r.state       = ST_HALT;
                                            end
                                        end
                                        CMD_SKIP: begin
                                            next_r.resume_flag = 1'b0;
                                            next_r.state       = ST_FUNC;
                                        end
                                        CMD_RESUME: begin
                                            next_r.state = r.resume_flag ? ST_FUNC
                                                                         : ST_HALT;
                                        end
                                        CMD_FAST_SKIP: begin
                                            next_r.resume_flag     = 1'b0;
                                            next_r.fast_speed_flag = 1'b1;
                                            next_r.state           = ST_FUNC;
                                        end
                                        default: begin
                                            next_r.state = ST_HALT;
                                        end
                                    endcase
                                end
                            end
                            ST_READ_ID: begin
                                next_r.idx = r.idx + 1'b1;
                                if (r.idx == 6'd63) begin
                                    next_r.state = ST_FUNC;
                                end
                            end
                            ST_MATCH: begin
                                next_r.idx  = r.idx + 1'b1;
                                next_r.mism = r.mism | (rx_bit != r.rom_id[r.idx]);
                                if (r.idx == 6'd63) begin
                                    if (next_r.mism) begin
                                        next_r.state       = ST_HALT;
                                        next_r.resume_flag = 1'b0;
                                        if (r.cmd == CMD_FAST_MATCH) begin
                                            next_r.fast_speed_flag = r.fast_prev;
                                        end
                                    end else begin
                                        next_r.state       = ST_FUNC;
                                        next_r.resume_flag = 1'b1;
                                    end
                                end
                            end
                            default: begin
                                // Search triplet: true bit, complement, master choice
                                if (r.phase != 2'd2) begin
                                    next_r.phase = r.phase + 1'b1;
                                end else if (rx_bit != r.rom_id[r.idx]) begin
                                    next_r.state       = ST_HALT;
                                    next_r.resume_flag = 1'b0;
                                end else if (r.idx == 6'd63) begin
                                    next_r.state       = ST_FUNC;
                                    next_r.resume_flag = 1'b1;
                                end else begin
                                    next_r.idx   = r.idx + 1'b1;
                                    next_r.phase = 2'd0;
                                end
                            end
                        endcase
                    end else if (r.slot_on) begin
                        next_r.cnt = r.cnt + 1'b1;
                    end
                end
                default: begin
                    next_r.state = ST_HALT;
                end
            endcase
        end
        next_r.fn_active = (next_r.state == ST_FUNC);

        // Fixed single wait cycle: answer one cycle after the request shows
        next_r.waitrequest = 1'b1;
        if (r.waitrequest && (avs_req.read || avs_req.write)) begin
            next_r.waitrequest = 1'b0;
            next_r.readdata    = reg_read(r, avs_req.address, alarm_flags);
        end
        if (!r.waitrequest && avs_req.write) begin
            unique case (avs_req.address)
                REG_ID_LO:        next_r.rom_id[31:0]  = avs_req.writedata;
                REG_ID_HI:        next_r.rom_id[63:32] = avs_req.writedata;
                REG_ALARM_ENABLE: next_r.alarm_enable  = avs_req.writedata[3:0];
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            r                 <= '0;
            r.state           <= ST_HALT;
            r.pull_n          <= 1'b1;
            r.line_d          <= 1'b1;
            r.waitrequest     <= 1'b1;
            r.rom_id          <= ID_RESET;
            r.alarm_enable    <= ALARM_ENABLE_RESET;
        end else begin
            r <= next_r;
        end
    end

    // Open drain: the data level is always low, only the enable moves
    assign line_out        = 1'b0;
    assign line_oe_n       = r.pull_n;
    assign avs_waitrequest = r.waitrequest;
    assign avs_readdata    = r.readdata;
    assign fn_active       = r.fn_active;
    assign fast_speed_flag = r.fast_speed_flag;
    assign resume_flag     = r.resume_flag;
    assign bus_reset       = r.bus_reset;
endmodule
`default_nettype wire

/* File: dv/swr_rom_layer_monitor.sv */
// Port checker for the single-wire ROM layer.
// Assumes one clock domain; bound to every swr_rom_layer instance.
`timescale 1ns/1ns
`default_nettype none
module swr_rom_layer_monitor
    import swr_pkg::*;
#(
    parameter swr_cnt_type RST_STD_CYC  = SWR_RST_STD_CYC,
    parameter swr_cnt_type RST_LONG_CYC = SWR_RST_LONG_CYC
) (
    // Clock and reset
    input wire logic            clk,
    input wire logic            sys_rst,
    // Watched ports
    input wire logic            line_in,
    input wire logic            line_out,
    input wire logic            line_oe_n,
    input wire swr_avs_req_type avs_req,
    input wire logic            avs_waitrequest,
    input wire logic [31:0]     avs_readdata,
    input wire logic [4:0]      alarm_flags,
    input wire logic            fn_active,
    input wire logic            fast_speed_flag,
    input wire logic            resume_flag,
    input wire logic            bus_reset
);
    int low_run;
    always_ff @(posedge clk) low_run <= line_in ? 0 : low_run + 1;
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    out_zero_a: assert property (line_out == 1'b0) else $error("line driven high");
    rst_vals_a: assert property ($past(sys_rst) |-> avs_waitrequest && line_oe_n
        && !fn_active && !fast_speed_flag && !resume_flag) else $error("bad reset state");
    wait_one_a: assert property ((avs_req.read || avs_req.write) && avs_waitrequest
        |=> !avs_waitrequest) else $error("no answer after one wait cycle");
    wait_pulse_a: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("answer longer than one cycle");
    flag_read_a: assert property (!avs_waitrequest && avs_req.read
        && avs_req.address == REG_ALARM_FLAGS |-> avs_readdata == {27'h0, $past(alarm_flags)})
        else $error("alarm flag read wrong");
    rst_len_a: assert property (bus_reset |-> low_run >=
        (fast_speed_flag ? int'(SWR_RST_FAST_CYC) : int'(RST_STD_CYC)))
        else $error("reset seen on a short low");
    long_clr_a: assert property ($rose(line_in) && low_run >= RST_LONG_CYC
        |-> ##[1:10] !fast_speed_flag) else $error("long reset kept fast speed");
    fn_quiet_a: assert property (fn_active && $past(fn_active) |-> line_oe_n)
        else $error("pull during function phase");
    pulse_one_a: assert property (bus_reset |=> !bus_reset) else $error("reset pulse long");
endmodule
bind swr_rom_layer swr_rom_layer_monitor #(.RST_STD_CYC(RST_STD_CYC),
    .RST_LONG_CYC(RST_LONG_CYC)) swr_rom_layer_monitor_inst (.clk(clk), .sys_rst(sys_rst),
    .line_in(line_in), .line_out(line_out), .line_oe_n(line_oe_n), .avs_req(avs_req),
    .avs_waitrequest(avs_waitrequest), .avs_readdata(avs_readdata), .alarm_flags(alarm_flags),
    .fn_active(fn_active), .fast_speed_flag(fast_speed_flag), .resume_flag(resume_flag),
    .bus_reset(bus_reset));
`default_nettype wire

/* File: dv/swr_line_master.sv */
// Behavioural bus master on the single-wire line, with the pull-up.
// Assumes the device slot counts at 100 MHz; the bench sets fast.
`timescale 1ns/1ns
`default_nettype none
module swr_line_master (
    // Clock
    input  wire logic clk,
    // Device pin and wired line
    input  wire logic line_out,
    input  wire logic line_oe_n,
    output logic      line
);
    logic m_low = 1'b0;
    bit   fast  = 1'b0;
    // Pull-up: the line rests high when nobody pulls
    assign line = !(m_low || (!line_oe_n && !line_out));
    task automatic slot(input logic b, output logic r);
        int s;
        int p;
        int lo;
        s = fast ? 300 : 3000;
        p = fast ? 800 : 6500;
        lo = b ? 10 : s + 40;
        m_low <= 1'b1;
        repeat (lo) @(posedge clk);
        m_low <= 1'b0;
        repeat (s / 5) @(posedge clk);
        r = line;
        repeat (p - lo - s / 5) @(posedge clk);
    endtask
    task automatic rst(input int n, output logic pres);
        pres = 1'b0;
        m_low <= 1'b1;
        repeat (n) @(posedge clk);
        m_low <= 1'b0;
        for (int i = 0; i < 5000; i++) begin
            @(posedge clk);
            if (!line) pres = 1'b1;
            else if (pres) break;
        end
        repeat (200) @(posedge clk);
    endtask
    task automatic triplet(input logic pick, input logic keep, output logic a, output logic b);
        logic w;
        logic r;
        slot(1'b1, a);
        slot(1'b1, b);
        // Both reads low: slaves differ here, so the caller's pick decides
        w = (!a && !b) ? pick : (keep ? a : b);
        slot(w, r);
    endtask
    task automatic tx(input logic [7:0] v);
        logic r;
        for (int i = 0; i < 8; i++) slot(v[i], r);
    endtask
endmodule
`default_nettype wire

/* File: dv/swr_rom_layer_tb.sv */
// Self-checking bench for the single-wire ROM layer.
// Assumes the line master model and the bound port checker.
`timescale 1ns/1ns
`default_nettype none
module swr_rom_layer_tb;
    import swr_pkg::*;
    logic            clk = 1'b0;
    logic            sys_rst = 1'b1;
    swr_avs_req_type avs_req = '0;
    logic [4:0]      alarm_flags = 5'h12;
    logic            line;
    logic            line_out;
    logic            line_oe_n;
    logic            avs_waitrequest;
    logic [31:0]     avs_readdata;
    logic            fn_active;
    logic            fast_speed_flag;
    logic            resume_flag;
    int              errors = 0;
    int              check_count = 0;
    always #5 clk = ~clk;
    // Write-0 slots at standard speed must stay under the reset threshold
    swr_rom_layer #(.RST_STD_CYC(17'hfa0), .RST_LONG_CYC(17'h1770), .PDL_STD_CYC(17'h64))
        swr_rom_layer_inst (.clk(clk), .sys_rst(sys_rst), .line_in(line), .line_out(line_out),
        .line_oe_n(line_oe_n), .avs_req(avs_req), .avs_waitrequest(avs_waitrequest),
        .avs_readdata(avs_readdata), .alarm_flags(alarm_flags), .fn_active(fn_active),
        .fast_speed_flag(fast_speed_flag), .resume_flag(resume_flag), .bus_reset());
    swr_line_master swr_line_master_inst (.clk(clk), .line_out(line_out),
        .line_oe_n(line_oe_n), .line(line));
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        avs_req <= '{read: !w, write: w, address: a, writedata: d};
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_req <= '0;
        @(posedge clk);
    endtask
    task automatic t_regs();
        logic [31:0] q;
        bus(1'b0, REG_ALARM_ENABLE, 32'h0, q);
        chk(q, 64'h0);
        bus(1'b0, REG_ID_LO, 32'h0, q);
        chk(q, ID_RESET[31:0]);
        bus(1'b1, REG_ALARM_FLAGS, 32'h0, q);
        bus(1'b0, REG_ALARM_FLAGS, 32'h0, q);
        chk(q, 64'h12);
        bus(1'b0, 12'h100, 32'h0, q);
        chk(q, 64'h0);
        bus(1'b1, REG_ALARM_ENABLE, 32'h5, q);
        bus(1'b0, REG_ALARM_ENABLE, 32'h0, q);
        chk(q, 64'h5);
    endtask
    task automatic t_fast_skip();
        logic p;
        swr_line_master_inst.rst(4500, p);
        chk({fn_active, p}, 64'h1);
        swr_line_master_inst.tx(CMD_FAST_SKIP);
        swr_line_master_inst.fast = 1'b1;
        chk({fast_speed_flag, fn_active, resume_flag}, 64'h6);
    endtask
    task automatic t_alarm_search();
        logic        p;
        logic        a;
        logic        b;
        logic [31:0] q;
        swr_line_master_inst.rst(1500, p);
        swr_line_master_inst.tx(CMD_ALM_SEARCH);
        swr_line_master_inst.triplet(1'b0, 1'b1, a, b);
        chk({a, b}, {ID_RESET[0], ~ID_RESET[0]});
        // Take the other branch: a lone slave must drop out here
        swr_line_master_inst.triplet(1'b0, 1'b0, a, b);
        chk({a, b}, {ID_RESET[1], ~ID_RESET[1]});
        swr_line_master_inst.slot(1'b1, a);
        chk({a, fn_active, resume_flag}, 64'h4);
        bus(1'b0, REG_LINK_STATUS, 32'h0, q);
        chk(q, 64'h2);
    endtask
    task automatic t_read_id();
        logic        p;
        logic        r;
        logic [63:0] id;
        swr_line_master_inst.rst(1500, p);
        chk({fast_speed_flag, p}, 64'h3);
        swr_line_master_inst.tx(CMD_READ_ID);
        for (int i = 0; i < 64; i++) begin
            swr_line_master_inst.slot(1'b1, r);
            id[i] = r;
        end
        chk(id, ID_RESET);
        chk(fn_active, 64'h1);
    endtask
    task automatic t_bad_code();
        logic p;
        swr_line_master_inst.rst(1500, p);
        swr_line_master_inst.tx(8'h00);
        chk({fn_active, resume_flag}, 64'h0);
        swr_line_master_inst.rst(6500, p);
        swr_line_master_inst.fast = 1'b0;
        chk({fast_speed_flag, p}, 64'h1);
    endtask
    task automatic report_and_stop();
        $display("errors=%0d check_count=%0d", errors, check_count);
        if (errors == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial begin
        #3000000;
        errors++;
        report_and_stop();
    end
    initial begin
        repeat (6) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        t_regs();
        t_fast_skip();
        t_alarm_search();
        t_read_id();
        t_bad_code();
        report_and_stop();
    end
endmodule
`default_nettype wire
